// >>> hdl/tfs_defs.vh
// Register map, field positions, reset values and codes for the frame synchronizer
`ifndef TFS_DEFS_VH
`define TFS_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define TFS_OFF_CTRL      12'h000
`define TFS_OFF_PATTERN   12'h004
`define TFS_OFF_FRAMELEN  12'h008
`define TFS_OFF_TOL       12'h00C
`define TFS_OFF_STATUS    12'h010
`define TFS_OFF_COUNTS    12'h014

// ****************************************
// Control fields
// ****************************************
`define TFS_CTRL_EN       0
`define TFS_CTRL_BEST     1
`define TFS_CTRL_INV      2
`define TFS_CTRL_TRL      3
`define TFS_CTRL_TIME     4
`define TFS_CTRL_DERAND   5
`define TFS_CTRL_SRC_LO   8
`define TFS_CTRL_SRC_HI   10

// ****************************************
// Tolerance fields
// ****************************************
`define TFS_TOL_STOL_LO   0
`define TFS_TOL_CTOL_LO   8
`define TFS_TOL_LTOL_LO   16
`define TFS_TOL_CCNT_LO   24
`define TFS_TOL_FLY_LO    28

// ****************************************
// Status fields
// ****************************************
`define TFS_STAT_MODE_LO  0
`define TFS_STAT_INV      2
`define TFS_STAT_BTS      3
`define TFS_STAT_ERR_LO   4

// ****************************************
// Reset values
// ****************************************
`define TFS_RST_CTRL      32'h0000_0008
`define TFS_RST_PATTERN   32'h1ACF_FC1D
`define TFS_RST_FRAMELEN  16'h0400
`define TFS_RST_TOL       32'h3100_0000

// ****************************************
// Mode codes, widths and limits
// ****************************************
`define TFS_MODE_SEARCH   2'h0
`define TFS_MODE_CHECK    2'h1
`define TFS_MODE_LOCK     2'h2
`define TFS_MODE_FLY      2'h3
`define TFS_PAT_BITS      32
`define TFS_ERR_MAX       3'h7
`define TFS_SYNC_STAGES   2

`endif

// >>> hdl/tfs_density_decode.v
// Transition-density decoder: additive pseudo-random sequence removal per frame
`timescale 1ns/1ps

module tfs_density_decode #(
  parameter SEED = 8'hFF                  // Sequence start value at each frame
) (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Control
  input  wire       enable,              // Decoding on
  input  wire       restart,             // New frame starts: reload sequence
  input  wire       step,                // One payload bit consumed
  // Data
  input  wire       bit_in,              // Synchronized bit
  output wire       bit_out              // Decoded bit
);

  // ****************************************
  // Sequence generator
  // ****************************************
  reg  [7:0] lfsr;                       // Sequence state, MSB is next output
  wire       fb;                         // Feedback of x^8+x^7+x^5+x^3+1

  assign fb      = lfsr[7] ^ lfsr[6] ^ lfsr[4] ^ lfsr[2];
  assign bit_out = enable ? (bit_in ^ lfsr[7]) : bit_in;

  // Restart wins over step so each frame decodes from the same seed
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfsr <= 8'hFF;
    end else if (restart) begin
      lfsr <= SEED;
    end else if (step) begin
      lfsr <= {lfsr[6:0], fb};
    end
  end

endmodule // tfs_density_decode

// >>> hdl/tfs_frame_sync.v
// Telemetry frame synchronizer: correlator, four-mode sync, word output, APB registers
`timescale 1ns/1ps
`include "tfs_defs.vh"

module tfs_frame_sync #(
  parameter NSRC = 6                     // Number of selectable serial sources
) (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Serial sources
  input  wire [NSRC-1:0] src_clk,
  input  wire [NSRC-1:0] src_data,
  // Serial front-panel mirror
  output reg         mirror_clk,
  output reg         mirror_data,
  // Parallel backplane words
  output reg  [15:0] word_data,
  output reg         word_mark,
  output reg         word_valid
);

  // ****************************************
  // Mode codes
  // ****************************************
  localparam [1:0] M_SEARCH = `TFS_MODE_SEARCH;
  localparam [1:0] M_CHECK  = `TFS_MODE_CHECK;
  localparam [1:0] M_LOCK   = `TFS_MODE_LOCK;
  localparam [1:0] M_FLY    = `TFS_MODE_FLY;

  // ****************************************
  // Registers seen by software
  // ****************************************
  reg  [31:0] ctrl;                      // Enables and source select
  reg  [31:0] pattern;                   // Sync pattern for the session
  reg  [15:0] frame_len;                 // Frame length in bytes
  reg  [31:0] tol;                       // Tolerances and frame counts
  reg         bts_flag;                  // Sticky back-to-search event
  reg  [15:0] lock_frames;               // Frames output in lock
  reg  [15:0] fly_frames;                // Frames output in flywheel

  wire        en       = ctrl[`TFS_CTRL_EN];
  wire        best_en  = ctrl[`TFS_CTRL_BEST];
  wire        inv_en   = ctrl[`TFS_CTRL_INV];
  wire        trl_en   = ctrl[`TFS_CTRL_TRL];
  wire        time_en  = ctrl[`TFS_CTRL_TIME];
  wire        der_en   = ctrl[`TFS_CTRL_DERAND];
  wire [2:0]  src_sel  = ctrl[`TFS_CTRL_SRC_HI:`TFS_CTRL_SRC_LO];
  wire [5:0]  stol     = tol[`TFS_TOL_STOL_LO+5:`TFS_TOL_STOL_LO];
  wire [5:0]  ctol     = tol[`TFS_TOL_CTOL_LO+5:`TFS_TOL_CTOL_LO];
  wire [5:0]  ltol     = tol[`TFS_TOL_LTOL_LO+5:`TFS_TOL_LTOL_LO];
  wire [3:0]  chk_need = tol[`TFS_TOL_CCNT_LO+3:`TFS_TOL_CCNT_LO];
  wire [3:0]  fly_lim  = tol[`TFS_TOL_FLY_LO+3:`TFS_TOL_FLY_LO];

  // ****************************************
  // Input synchronisers, one pair per source pin
  // ****************************************
  reg  [NSRC-1:0] clk_s1;                // First stage, read only by second
  reg  [NSRC-1:0] clk_s2;                // Stable source clocks
  reg  [NSRC-1:0] dat_s1;
  reg  [NSRC-1:0] dat_s2;

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_sync
      // Two flops per pin; sources may run from unrelated oscillators
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          clk_s1[gi] <= 1'b0;
          clk_s2[gi] <= 1'b0;
          dat_s1[gi] <= 1'b0;
          dat_s2[gi] <= 1'b0;
        end else begin
          clk_s1[gi] <= src_clk[gi];
          clk_s2[gi] <= clk_s1[gi];
          dat_s1[gi] <= src_data[gi];
          dat_s2[gi] <= dat_s1[gi];
        end
      end
    end
  endgenerate

  // Selected source; an out-of-range select reads as idle
  wire sel_ok  = (src_sel < NSRC);
  wire sel_clk = sel_ok ? clk_s2[src_sel] : 1'b0;
  wire sel_dat = sel_ok ? dat_s2[src_sel] : 1'b0;
  reg  clk_prev;                         // Previous selected clock level
  wire bit_stb = sel_clk & ~clk_prev & en;  // Rising edge of link clock

  // ****************************************
  // Correlator
  // ****************************************
  reg  [31:0] shift;                     // Last 32 received bits
  wire [31:0] shift_n = {shift[30:0], sel_dat};

  // Count of ones in a word, 0 to 32
  function [5:0] popcnt;
    input [31:0] v;
    integer i;
    begin
      popcnt = 6'h00;
      for (i = 0; i < 32; i = i + 1) begin
        popcnt = popcnt + {5'h00, v[i]};
      end
    end
  endfunction

  wire [5:0] err_t   = popcnt(shift_n ^ pattern);
  wire [5:0] err_i   = 6'h20 - err_t;    // Errors against inverted pattern
  reg        inv;                        // Stream found inverted
  wire [5:0] err_use = inv ? err_i : err_t;
  wire       hit_t   = (err_t <= stol);
  wire       hit_i   = inv_en & (err_i <= stol);

  // ****************************************
  // Frame position
  // ****************************************
  reg  [1:0]  mode;                      // Current sync mode
  reg  [18:0] pos;                       // Bits since last pattern end
  wire [18:0] fbits   = {frame_len, 3'h0};
  wire        at_exp  = (pos == fbits - 19'h1);
  wire        at_last = (pos == fbits - 19'h21);   // Last payload bit
  wire        payload = (pos <= fbits - 19'h21);

  // ****************************************
  // Frame state and counters
  // ****************************************
  reg  [3:0]  chk_cnt;                   // Valid patterns seen in check
  reg  [3:0]  fly_cnt;                   // Consecutive flywheel frames
  reg         first;                     // Still inside first frame after search
  reg  [5:0]  cand_err;                  // Errors of current candidate
  reg  [1:0]  frm_mode;                  // Mode the current frame is output in
  reg  [2:0]  frm_err;                   // Saturated pattern errors of frame
  reg         frm_bts;                   // Current frame is back-to-search
  reg  [31:0] tc;                        // Free-running timecode
  reg  [31:0] frm_time;                  // Timecode at frame start
  reg  [15:0] pk_sr;                     // Word assembly shift register
  reg  [3:0]  pk_cnt;                    // Bits in assembly
  reg  [1:0]  trl_idx;                   // Trailer word being sent
  reg         trl_run;                   // Trailer in progress

  // ****************************************
  // Mode decision at the expected position
  // ****************************************
  reg  [1:0] next_mode;
  reg        next_bts;
  reg  [3:0] next_chk;
  reg  [3:0] next_fly;

  // Evaluated every bit; only used when the expected position is reached
  always @* begin
    next_mode = mode;
    next_bts  = 1'b0;
    next_chk  = chk_cnt;
    next_fly  = fly_cnt;
    case (mode)
      M_CHECK: begin
        if (err_use <= ctol) begin
          next_chk = chk_cnt + 4'h1;
          if (next_chk >= chk_need) begin
            next_mode = M_LOCK;
          end
        end else begin
          next_mode = M_SEARCH;
        end
      end
      M_LOCK: begin
        if (err_use > ltol) begin
          next_mode = M_FLY;
          next_fly  = 4'h1;
          next_bts  = (next_fly >= fly_lim);
        end
      end
      M_FLY: begin
        if (frm_bts) begin
          next_mode = M_SEARCH;
        end else if (err_use <= ltol) begin
          next_mode = M_LOCK;
          next_fly  = 4'h0;
        end else begin
          next_fly  = fly_cnt + 4'h1;
          next_bts  = (next_fly >= fly_lim);
        end
      end
      default: begin
        next_mode = M_SEARCH;
      end
    endcase
  end

  // ****************************************
  // Decoder after synchronisation
  // ****************************************
  wire bit_inv = sel_dat ^ inv;          // Polarity-corrected bit
  wire bit_dec;                          // Decoded payload bit
  wire frm_start;                        // A new frame begins after this bit
  wire pay_stb = bit_stb & (mode != M_SEARCH) & payload;

  assign frm_start = bit_stb & (((mode == M_SEARCH) & (hit_t | hit_i)) |
                     ((mode != M_SEARCH) & at_exp & (next_mode != M_SEARCH)));

  // Decoding only touches bits that already passed frame processing
  tfs_density_decode u_dec (
    .clk     (clk),
    .resetn  (resetn),
    .enable  (der_en),
    .restart (frm_start),
    .step    (pay_stb),
    .bit_in  (bit_inv),
    .bit_out (bit_dec)
  );

  wire [2:0] err_sat = (err_use > 6'h07) ? `TFS_ERR_MAX : err_use[2:0];
  wire [2:0] err_ts  = (err_t > 6'h07) ? `TFS_ERR_MAX : err_t[2:0];

  // ****************************************
  // Synchronisation engine and word output
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_prev    <= 1'b0;
      shift       <= 32'h0000_0000;
      mode        <= M_SEARCH;
      pos         <= 19'h0_0000;
      inv         <= 1'b0;
      chk_cnt     <= 4'h0;
      fly_cnt     <= 4'h0;
      first       <= 1'b0;
      cand_err    <= 6'h00;
      frm_mode    <= M_SEARCH;
      frm_err     <= 3'h0;
      frm_bts     <= 1'b0;
      tc          <= 32'h0000_0000;
      frm_time    <= 32'h0000_0000;
      pk_sr       <= 16'h0000;
      pk_cnt      <= 4'h0;
      trl_idx     <= 2'h0;
      trl_run     <= 1'b0;
      word_data   <= 16'h0000;
      word_mark   <= 1'b0;
      word_valid  <= 1'b0;
      mirror_clk  <= 1'b0;
      mirror_data <= 1'b0;
    end else begin
      clk_prev    <= sel_clk;
      tc          <= tc + 32'h0000_0001;
      word_valid  <= 1'b0;
      // Front panel follows the selected source as it is processed
      mirror_clk  <= sel_clk;
      mirror_data <= sel_dat;
      if (!en) begin
        // Disable drops sync; software re-arms by setting enable again
        mode    <= M_SEARCH;
        trl_run <= 1'b0;
        pk_cnt  <= 4'h0;
      end else if (trl_run) begin
        // Trailer words go out between serial bits, one per clock
        word_valid <= 1'b1;
        if (trl_idx == 2'h0) begin
          word_data <= {9'h000, frm_bts, inv, frm_mode, frm_err};
        end else if (trl_idx == 2'h1) begin
          word_data <= frm_time[31:16];
        end else begin
          word_data <= frm_time[15:0];
        end
        word_mark <= (trl_idx == 2'h2) | ((trl_idx == 2'h0) & ~time_en);
        if ((trl_idx == 2'h2) | ((trl_idx == 2'h0) & ~time_en)) begin
          trl_run <= 1'b0;
        end else begin
          trl_idx <= trl_idx + 2'h1;
        end
      end
      if (bit_stb) begin
        shift <= shift_n;
        if (mode == M_SEARCH) begin
          // Hunt at every bit position
          if (hit_t | hit_i) begin
            inv      <= ~hit_t;
            cand_err <= hit_t ? err_t : err_i;
            frm_err  <= hit_t ? err_ts : ((err_i > 6'h07) ? `TFS_ERR_MAX : err_i[2:0]);
            pos      <= 19'h0_0000;
            first    <= 1'b1;
            chk_cnt  <= 4'h0;
            fly_cnt  <= 4'h0;
            frm_bts  <= 1'b0;
            frm_time <= tc;
            pk_cnt   <= 4'h0;
            if (chk_need == 4'h0) begin
              mode     <= M_LOCK;
              frm_mode <= M_LOCK;
            end else begin
              mode     <= M_CHECK;
              frm_mode <= M_CHECK;
            end
          end
        end else if (at_exp) begin
          // Expected pattern position closes the frame
          mode    <= next_mode;
          chk_cnt <= next_chk;
          fly_cnt <= next_fly;
          first   <= 1'b0;
          pos     <= 19'h0_0000;
          pk_cnt  <= 4'h0;
          if (next_mode != M_SEARCH) begin
            frm_mode <= next_mode;
            frm_err  <= err_sat;
            frm_bts  <= next_bts;
            frm_time <= tc;
          end
        end else if (first & best_en & (err_use < cand_err) &
                     (err_use <= stol)) begin
          // Better candidate inside the first frame moves the frame start
          pos      <= 19'h0_0000;
          cand_err <= err_use;
          frm_err  <= err_sat;
          frm_time <= tc;
          pk_cnt   <= 4'h0;
        end else begin
          pos <= pos + 19'h0_0001;
          if (payload) begin
            pk_sr  <= {pk_sr[14:0], bit_dec};
            pk_cnt <= pk_cnt + 4'h1;
            if (pk_cnt == 4'hF) begin
              word_valid <= 1'b1;
              word_data  <= {pk_sr[14:0], bit_dec};
              word_mark  <= at_last & ~trl_en & ~time_en;
              if (at_last & (trl_en | time_en)) begin
                trl_run <= 1'b1;
                trl_idx <= trl_en ? 2'h0 : 2'h1;
              end
            end
          end
        end
      end
    end
  end

  // ****************************************
  // APB slave: one wait state, pready registered
  // ****************************************
  wire acc    = psel & penable & pready;        // Completing access
  wire wr_acc = acc & pwrite;
  wire bts_set = frm_start & next_bts;          // Back-to-search frame begins
  wire map_ok = (paddr == `TFS_OFF_CTRL)   | (paddr == `TFS_OFF_PATTERN) |
                (paddr == `TFS_OFF_FRAMELEN) | (paddr == `TFS_OFF_TOL) |
                (paddr == `TFS_OFF_STATUS) | (paddr == `TFS_OFF_COUNTS);

  // Register writes, sticky flag and frame counters
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl        <= `TFS_RST_CTRL;
      pattern     <= `TFS_RST_PATTERN;
      frame_len   <= `TFS_RST_FRAMELEN;
      tol         <= `TFS_RST_TOL;
      bts_flag    <= 1'b0;
      lock_frames <= 16'h0000;
      fly_frames  <= 16'h0000;
    end else begin
      if (wr_acc) begin
        if (paddr == `TFS_OFF_CTRL) begin
          ctrl <= pwdata;
        end else if (paddr == `TFS_OFF_PATTERN) begin
          pattern <= pwdata;
        end else if (paddr == `TFS_OFF_FRAMELEN) begin
          frame_len <= pwdata[15:0];
        end else if (paddr == `TFS_OFF_TOL) begin
          tol <= pwdata;
        end
      end
      // Set beats a same-cycle write-one-to-clear
      if (bts_set) begin
        bts_flag <= 1'b1;
      end else if (wr_acc & (paddr == `TFS_OFF_STATUS) & pwdata[`TFS_STAT_BTS]) begin
        bts_flag <= 1'b0;
      end
      // Counting at frame start; wrap rather than saturate
      if (frm_start & (next_mode == M_LOCK | (mode == M_SEARCH & chk_need == 4'h0))) begin
        lock_frames <= lock_frames + 16'h0001;
      end
      if (frm_start & (mode != M_SEARCH) & (next_mode == M_FLY)) begin
        fly_frames <= fly_frames + 16'h0001;
      end
    end
  end

  // Read data and handshake
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~map_ok;
      prdata  <= 32'h0000_0000;
      if (psel & penable & ~pready & ~pwrite) begin
        if (paddr == `TFS_OFF_CTRL) begin
          prdata <= ctrl;
        end else if (paddr == `TFS_OFF_PATTERN) begin
          prdata <= pattern;
        end else if (paddr == `TFS_OFF_FRAMELEN) begin
          prdata <= {16'h0000, frame_len};
        end else if (paddr == `TFS_OFF_TOL) begin
          prdata <= tol;
        end else if (paddr == `TFS_OFF_STATUS) begin
          prdata <= {22'h00_0000, cand_err, bts_flag, inv, mode};
        end else if (paddr == `TFS_OFF_COUNTS) begin
          prdata <= {fly_frames, lock_frames};
        end
      end
    end
  end

endmodule // tfs_frame_sync

// >>> bench/tfs_fs_asserts.sv
// Port-level checker for the frame synchronizer, bound to its top module
`timescale 1ns/1ps
module tfs_fs_asserts (
  // Clock and reset
  input wire        clk,
  input wire        resetn,
  // APB slave
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Backplane words
  input wire [15:0] word_data,
  input wire        word_mark,
  input wire        word_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // First access cycle of a transfer
  sequence s_access;
    psel && $rose(penable);
  endsequence
  a_pready_wait: assert property (s_access |=> pready)
    else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_pready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_unmapped_err: assert property (pready && paddr > 12'h014 |-> pslverr)
    else $error("unmapped address accepted");
  a_mapped_ok: assert property (pready && paddr[1:0] == 2'h0 && paddr <= 12'h014 |-> !pslverr)
    else $error("mapped address refused");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  // Word and mark only move together with a valid pulse
  a_word_hold: assert property (!word_valid |-> $stable(word_data) && $stable(word_mark))
    else $error("word changed without valid");
  a_mark_last: assert property (word_valid && word_mark |=> !word_valid)
    else $error("word follows unit end");
endmodule // tfs_fs_asserts

bind tfs_frame_sync tfs_fs_asserts u_chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .word_data(word_data), .word_mark(word_mark), .word_valid(word_valid));

// >>> bench/tfs_src_model.sv
// Serial telemetry source: repeating frames of sync pattern and fixed payload
`timescale 1ns/1ps
module tfs_src_model #(
  parameter PAT = 32'h1ACFFC1D,          // Sync pattern, first bit is bit 31
  parameter PAY = 32'hC35A0F96           // Payload of each frame
) (
  // Control
  input  wire run,                       // Send frames
  input  wire pat_err,                   // Corrupt one pattern bit
  // Serial link
  output reg  sclk,
  output reg  sdata
);
  integer i;                             // Bit index within the frame
  // Own timebase, unrelated in phase to the system clock
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    #7;
    forever begin
      if (run !== 1'b1) begin
        // Idle: clock stands, data keeps moving so nothing stale reads as valid
        sdata = ~sdata;
        #100;
      end else begin
        for (i = 63; i >= 0; i = i - 1) begin
          // Pattern first, then payload, MSB first
          sdata = (i > 31) ? (PAT[i-32] ^ (pat_err && i == 32)) : PAY[i];
          #100 sclk = 1'b1;
          #100 sclk = 1'b0;
        end
      end
    end
  end
endmodule // tfs_src_model

// >>> bench/tb.sv
// Self-checking bench for the frame synchronizer
`timescale 1ns/1ps
`include "tfs_defs.vh"
module tb;
  reg         clk, resetn, psel, penable, pwrite, run, pat_err;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, r;
  reg         e, wm;
  reg  [15:0] wd;
  wire [31:0] prdata;
  wire [15:0] word_data;
  wire        pready, pslverr, word_mark, word_valid, sclk, sdata;
  wire        mclk, mdat;         // Front-panel mirror pins
  wire [5:0]  src_clk  = {sclk, 5'h00};   // Model sits on the last source
  wire [5:0]  src_data = {sdata, 5'h00};
  integer     err_count = 0, comparisons = 0, cyc = 0;
  tfs_frame_sync uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_clk(src_clk), .src_data(src_data), .mirror_clk(mclk),
    .mirror_data(mdat), .word_data(word_data), .word_mark(word_mark), .word_valid(word_valid));
  tfs_src_model m (.run(run), .pat_err(pat_err), .sclk(sclk), .sdata(sdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard: whole run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count = err_count + 1;
      conclude;
    end
  end
  task conclude;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input [31:0] x, input [31:0] g);
    comparisons = comparisons + 1;
    if (g !== x) begin
      err_count = err_count + 1;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task get_word;
    do @(posedge clk); while (word_valid !== 1'b1);
    wd = word_data;
    wm = word_mark;
  endtask
  task t_regs;
    apb(0, `TFS_OFF_CTRL, 0);    chk("ctrl", `TFS_RST_CTRL, r);
    apb(0, `TFS_OFF_PATTERN, 0); chk("pattern", `TFS_RST_PATTERN, r);
    apb(0, `TFS_OFF_FRAMELEN, 0); chk("framelen", {16'h0000, `TFS_RST_FRAMELEN}, r);
    apb(0, `TFS_OFF_TOL, 0);     chk("tol", `TFS_RST_TOL, r);
    apb(0, `TFS_OFF_STATUS, 0);  chk("mode", `TFS_MODE_SEARCH, r[1:0]);
    apb(1, 12'h020, 32'hFFFFFFFF); chk("wr slverr", 1, e);
    apb(0, 12'h020, 0);          chk("rd unmapped", 0, r);
    $display("t_regs done");
  endtask
  // Unit of two payload words and the quality trailer; trailer checked in mark, mode and error fields
  task unit(input [1:0] mode, input [31:0] pay);
    get_word; chk("w0", pay[31:16], wd);
    chk("m0", 0, wm);
    get_word; chk("w1", pay[15:0], wd);
    chk("m1", 0, wm);
    get_word; chk("m2", 1, wm);
    chk("qmode", mode, wd[4:3]);
    chk("qerr", 0, wd[2:0]);
  endtask
  task t_lock;
    apb(1, `TFS_OFF_FRAMELEN, 32'h8);
    apb(1, `TFS_OFF_CTRL, 32'h0509);
    run <= 1'b1;
    unit(`TFS_MODE_CHECK, 32'hC35A0F96);
    // Mirror shows the bit in flight: two sync stages plus the output flop
    @(posedge sclk);
    repeat (4) @(posedge clk);
    chk("mirror", {1'b1, sdata}, {mclk, mdat});
    repeat (6) get_word;
    apb(0, `TFS_OFF_STATUS, 0); chk("lock", `TFS_MODE_LOCK, r[1:0]);
    // Frames two and three both started in lock
    apb(0, `TFS_OFF_COUNTS, 0); chk("lockcnt", 2, r[15:0]);
    $display("t_lock done");
  endtask
  task t_fly;
    pat_err <= 1'b1;
    // First missed pattern: next unit goes out in flywheel with one error
    repeat (3) get_word;
    chk("fmode", `TFS_MODE_FLY, wd[4:3]);
    chk("ferr", 1, wd[2:0]);
    // Third flywheel unit reaches the limit of three and carries the flag
    repeat (6) get_word;
    chk("qbts", 1, wd[6]);
    repeat (4096) @(posedge clk);
    apb(0, `TFS_OFF_STATUS, 0); chk("search", `TFS_MODE_SEARCH, r[1:0]);
    chk("bts", 1, r[3]);
    apb(0, `TFS_OFF_COUNTS, 0); chk("flycnt", 3, r[31:16]);
    apb(1, `TFS_OFF_STATUS, 32'h8);
    apb(0, `TFS_OFF_STATUS, 0); chk("bts clr", 0, r[3]);
    $display("t_fly done");
  endtask
  task t_zero;
    apb(1, `TFS_OFF_CTRL, 32'h0);
    apb(1, `TFS_OFF_TOL, 32'h30000000);
    pat_err <= 1'b0;
    // Density decoding on: payload is summed with the all-ones seeded sequence
    apb(1, `TFS_OFF_CTRL, 32'h0529);
    unit(`TFS_MODE_LOCK, 32'h3C40A0F0);
    $display("t_zero done");
  endtask
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, run, pat_err} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_lock;
    t_fly;
    t_zero;
    conclude;
  end
endmodule // tb
